// *** adc_conversion_control_regs.vh ***
// constants for the conversion control block: register offsets, fields, reset values, timing
// assumes inclusion by the design, checker and bench files of the block
`ifndef ADC_CONVERSION_CONTROL_REGS_VH
`define ADC_CONVERSION_CONTROL_REGS_VH

`define CTRL_REG_ADDR      8'hc5
`define RESULT_REG_ADDR    8'hc6
`define CTRL_RESET         8'h00
`define RESULT_RESET       8'h00
`define BIT_EXT_START_EN   5
`define BIT_DONE_FLAG      4
`define BIT_START_BUSY     3
`define CHAN_SEL_MSB       2
`define CONV_MACHINE_CYCLES 5'h18

`endif

// *** adc_conversion_control.v ***
// conversion control for an 8-bit successive conversion unit with an 8-input multiplexer
// assumes a special-function register port on the machine-cycle clock; sample and
// successive-approximation core outside, delivering its 8-bit code on sar_value_in
`timescale 1ns/100ps
`default_nettype none
`include "adc_conversion_control_regs.vh"

// Overview of operation
// - at conversion end, set done flag and load the result register
// - a running conversion ignores further starts from software or pin
// - starts arriving while busy or done are dropped, never queued
// - result register holds its value while the done flag is one
// - idle or power-down aborts a conversion in progress
// - idle leaves a finished result and its done flag intact
// - one write clearing done and setting start may launch a conversion
// - each conversion lasts 24 machine cycles from start to result
// - input chosen among eight analog inputs by the three-bit select field
// - control bits: 7-6 reserved, 5 ext enable, 4 done, 3 busy, 2-0 channel
// - external pin edge starts only when external start enable is one
// - done flag set when result ready; interrupt requested if enabled
// - software cannot set the done flag; service routine clears it
// - busy set by software or enabled pin, high during the whole conversion
// - busy cleared the cycle right after done is set
// - writing zero does not clear busy; only completion or an idle or power-down abort does
// - channel select written only when done and busy are both low
// - select field is binary, bit 2 most significant, 100 is input four
// - busy and done both high for at most one cycle at conversion end
module adc_conversion_control (
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    input  wire       sfr_wr_in,
    input  wire [7:0] sfr_addr_in,
    input  wire [7:0] sfr_wdata_in,
    output reg  [7:0] sfr_rdata_out,
    input  wire       ext_start_pin_in,
    input  wire       idle_in,
    input  wire       power_down_in,
    input  wire       irq_enable_in,
    input  wire [7:0] sar_value_in,
    output reg  [2:0] mux_select_out,
    output reg        conv_active_out,
    output reg        irq_out
);

////////////////////////////////////////////////////////////////////////////////
// state and registers

localparam ST_IDLE = 3'b001;
localparam ST_CONV = 3'b010;
localparam ST_DONE = 3'b100;

reg  [2:0] state;
reg  [2:0] next_state;
reg  [4:0] cycle_cnt;
reg        ext_start_enable;
reg        conversion_done_flag;
reg        start_busy_bit;
reg  [2:0] channel_select;
reg  [7:0] result_register;
reg        pin_meta;
reg        pin_sync;
reg        pin_prev;

wire ctrl_wr = sfr_wr_in && (sfr_addr_in == `CTRL_REG_ADDR);
wire sleep   = idle_in || power_down_in;
// the second synchroniser stage and its one-cycle delayed copy feed the edge detector
wire pin_rise = pin_sync && !pin_prev && ext_start_enable;
wire sw_start = ctrl_wr && sfr_wdata_in[`BIT_START_BUSY];
// the done flag seen by the start gate is the one after this write, so works
wire done_after_wr = conversion_done_flag &&
                     !(ctrl_wr && !sfr_wdata_in[`BIT_DONE_FLAG]);
wire start_ok = (sw_start || pin_rise) && !start_busy_bit && !done_after_wr
                && !sleep;
wire finish = (state == ST_CONV) && (cycle_cnt == `CONV_MACHINE_CYCLES - 5'h01);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        pin_meta <= 1'b0;
        pin_sync <= 1'b0;
        pin_prev <= 1'b0;
    end else begin
        pin_meta <= ext_start_pin_in;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (start_ok)
                next_state = ST_CONV;
        end
        ST_CONV: begin
            if (sleep)
                next_state = ST_IDLE;
            else if (finish)
                next_state = ST_DONE;
        end
        ST_DONE: begin
            next_state = ST_IDLE; // busy drops one cycle after done rises
        end
        default: next_state = ST_IDLE;
    endcase
end

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        state     <= ST_IDLE;
        cycle_cnt <= 5'h00;
    end else begin
        state <= next_state;
        if (state == ST_CONV && !sleep)
            cycle_cnt <= cycle_cnt + 5'h01;
        else
            cycle_cnt <= 5'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control register and result

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        ext_start_enable     <= 1'b0;
        conversion_done_flag <= 1'b0;
        start_busy_bit       <= 1'b0;
        channel_select       <= 3'h0;
        result_register      <= `RESULT_RESET;
    end else begin
        if (ctrl_wr)
            ext_start_enable <= sfr_wdata_in[`BIT_EXT_START_EN];
        // channel only changes while neither busy nor done
        if (ctrl_wr && !start_busy_bit && !conversion_done_flag)
            channel_select <= sfr_wdata_in[`CHAN_SEL_MSB:0];
        // set wins over a clear arriving in the same cycle; writes only clear
        if (finish && !sleep) begin
            conversion_done_flag <= 1'b1;
            result_register      <= sar_value_in;
        end else if (ctrl_wr && !sfr_wdata_in[`BIT_DONE_FLAG])
            conversion_done_flag <= 1'b0;
        // idle keeps a finished result: only the running conversion is dropped
        if (start_ok)
            start_busy_bit <= 1'b1;
        else if (state == ST_DONE || (state == ST_CONV && sleep))
            start_busy_bit <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs and read port

always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        sfr_rdata_out   <= `CTRL_RESET;
        mux_select_out  <= 3'h0;
        conv_active_out <= 1'b0;
        irq_out         <= 1'b0;
    end else begin
        if (sfr_addr_in == `CTRL_REG_ADDR)
            sfr_rdata_out <= {2'b00, ext_start_enable, conversion_done_flag,
                              start_busy_bit, channel_select};
        else if (sfr_addr_in == `RESULT_REG_ADDR)
            sfr_rdata_out <= result_register;
        else
            sfr_rdata_out <= 8'h00;
        mux_select_out  <= channel_select;
        conv_active_out <= (next_state == ST_CONV);
        irq_out         <= conversion_done_flag && irq_enable_in;
    end
end

endmodule
`default_nettype wire

// *** adc_ctrl_asserts.sv ***
// checker for the conversion control block
// bound to the design top, sees its ports only
`timescale 1ns/100ps
`default_nettype none
`include "adc_conversion_control_regs.vh"
module adc_ctrl_asserts (
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       sfr_wr_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       ext_start_pin_in,
    input wire logic       idle_in,
    input wire logic       power_down_in,
    input wire logic       irq_enable_in,
    input wire logic [2:0] mux_select_out,
    input wire logic       conv_active_out,
    input wire logic       irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [5:0] run; // saturates so a stuck busy cannot wrap back into range
    always @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in) run <= 6'h00;
        else run <= conv_active_out ? run + {5'h00, run != 6'h3f} : 6'h00;
    sequence s_halt; conv_active_out && (idle_in || power_down_in); endsequence
    // the mux output lags the channel field by one cycle, so skip the first two busy cycles
    sequence s_run2; conv_active_out ##1 conv_active_out ##1 conv_active_out; endsequence
    chk_busy_len: assert property (run <= 6'h18) else $error("busy too long");
    chk_abort_fast: assert property (s_halt |-> ##[1:3] !conv_active_out)
        else $error("no abort");
    chk_halt_block: assert property ((idle_in || power_down_in) && $past(idle_in || power_down_in)
        && !conv_active_out |=> !conv_active_out) else $error("start in idle");
    chk_mux_hold: assert property (s_run2 |-> $stable(mux_select_out))
        else $error("channel moved");
    chk_irq_gate: assert property (irq_out |-> $past(irq_enable_in)) else $error("irq ungated");
    chk_irq_hold: assert property (irq_out && irq_enable_in && !sfr_wr_in && !$past(sfr_wr_in)
        && !power_down_in |=> irq_out) else $error("done lost");
    chk_start_cause: assert property ($rose(conv_active_out) |-> $past(sfr_wr_in)
        || $past(ext_start_pin_in, 2) || $past(ext_start_pin_in, 3)) else $error("bad start");
    chk_unmapped_zero: assert property (sfr_addr_in != `CTRL_REG_ADDR && sfr_addr_in !=
        `RESULT_REG_ADDR |=> sfr_rdata_out == 8'h00) else $error("unmapped data");
    chk_reserved_zero: assert property (sfr_addr_in == `CTRL_REG_ADDR |=>
        sfr_rdata_out[7:6] == 2'b00) else $error("reserved set");
endmodule
bind adc_conversion_control adc_ctrl_asserts u_chk (.core_clk_in, .rst_n_in, .sfr_wr_in,
    .sfr_addr_in, .sfr_rdata_out, .ext_start_pin_in, .idle_in, .power_down_in, .irq_enable_in,
    .mux_select_out, .conv_active_out, .irq_out);
`default_nettype wire

// *** adc_conversion_control_bench.sv ***
// self-checking bench for the conversion control block
// drives register port and pins itself, no partner model
`timescale 1ns/100ps
`default_nettype none
`include "adc_conversion_control_regs.vh"
module adc_conversion_control_bench;
    logic       core_clk_in = 1'b0, rst_n_in = 1'b0, sfr_wr_in = 1'b0, idle_in = 1'b0;
    logic       ext_start_pin_in = 1'b0, power_down_in = 1'b0, irq_enable_in = 1'b1;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sar_value_in = 8'h00, res_m;
    wire  [7:0] sfr_rdata_out;
    wire  [2:0] mux_select_out;
    wire        conv_active_out, irq_out;
    integer     fails = 0, comparisons = 0, cycles = 0, seed = 32'h9403_ce17, n;
    adc_conversion_control dut (.core_clk_in, .rst_n_in, .sfr_wr_in, .sfr_addr_in,
        .sfr_wdata_in, .sfr_rdata_out, .ext_start_pin_in, .idle_in, .power_down_in,
        .irq_enable_in, .sar_value_in, .mux_select_out, .conv_active_out, .irq_out);
    initial forever #2 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles = cycles + 1;
        if (cycles > 3000) begin // generous, the run needs some 160 cycles
            fails = fails + 1;
            final_report;
        end
    end
    ////////////////////
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cmp(input string w, input [7:0] e, input [7:0] s);
        comparisons = comparisons + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    task rd(input string w, input [7:0] a, input [7:0] e);
        @(posedge core_clk_in) #1 sfr_addr_in = a;
        @(posedge core_clk_in) #1 cmp(w, e, sfr_rdata_out);
    endtask
    task wr(input [7:0] d);
        @(posedge core_clk_in) #1 sfr_wr_in = 1'b1;
        sfr_addr_in = `CTRL_REG_ADDR;
        sfr_wdata_in = d;
        @(posedge core_clk_in) #1 sfr_wr_in = 1'b0;
    endtask
    task pin; // held for six cycles so the synchroniser surely sees it
        @(posedge core_clk_in) #1 ext_start_pin_in = 1'b1;
        repeat (6) @(posedge core_clk_in);
        #1 ext_start_pin_in = 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        rd("ctrl", `CTRL_REG_ADDR, `CTRL_RESET);
        rd("result", `RESULT_REG_ADDR, `RESULT_RESET);
        rd("unmapped", 8'h80, 8'h00);
        wr(8'hc4);
        rd("ctrl", `CTRL_REG_ADDR, 8'h04);
        cmp("mux", 8'h04, {5'h00, mux_select_out});
        n = $random(seed);
        res_m = n[7:0];
        sar_value_in = res_m;
        wr(8'h0c);
        n = 0;
        while (irq_out !== 1'b1 && n < 40) @(posedge core_clk_in) #1 n = n + 1;
        cmp("latency", 8'h19, n[7:0]);
        rd("ctrl", `CTRL_REG_ADDR, 8'h14);
        rd("result", `RESULT_REG_ADDR, res_m);
        sar_value_in = ~res_m;
        wr(8'h1f);
        idle_in = 1'b1;
        rd("ctrl", `CTRL_REG_ADDR, 8'h14);
        idle_in = 1'b0;
        rd("result", `RESULT_REG_ADDR, res_m);
        res_m = ~res_m;
        wr(8'h08);
        wr(8'h00);
        rd("ctrl", `CTRL_REG_ADDR, 8'h0c);
        repeat (30) @(posedge core_clk_in);
        rd("result", `RESULT_REG_ADDR, res_m);
        wr(8'h04);
        wr(8'h0c);
        repeat (5) @(posedge core_clk_in);
        #1 power_down_in = 1'b1;
        rd("ctrl", `CTRL_REG_ADDR, 8'h04);
        power_down_in = 1'b0;
        pin;
        rd("ctrl", `CTRL_REG_ADDR, 8'h04);
        wr(8'h24);
        pin;
        repeat (30) @(posedge core_clk_in);
        rd("ctrl", `CTRL_REG_ADDR, 8'h34);
        final_report;
    end
endmodule
`default_nettype wire
